// ### logic/dual_event_timer.sv
/*
 * Two 8-bit timer/event counters with clear-and-start, square-wave, PWM and
 * 16-bit cascade operation, reached over an AXI4-Lite slave.
 * Assumes one clock aclk and a synchronous active-low reset; event pins are
 * asynchronous and are synchronised inside count_tick_gen.
 */
// The AXI4-Lite register port and the register addresses were decided locally.
`timescale 1ns/100ps
`include "timer_consts.svh"
module dual_event_timer
#(
	parameter int ADDR_W = 8
)
(
	input  wire logic              aclk,
	input  wire logic              aresetn,
	input  wire logic              awvalid,
	output logic                   awready,
	input  wire logic [ADDR_W-1:0] awaddr,
	input  wire logic              wvalid,
	output logic                   wready,
	input  wire logic [31:0]       wdata,
	input  wire logic [3:0]        wstrb,
	output logic                   bvalid,
	input  wire logic              bready,
	output logic [1:0]             bresp,
	input  wire logic              arvalid,
	output logic                   arready,
	input  wire logic [ADDR_W-1:0] araddr,
	output logic                   rvalid,
	input  wire logic              rready,
	output logic [31:0]            rdata,
	output logic [1:0]             rresp,
	input  wire logic              low_channel_event_pin,
	input  wire logic              high_channel_event_pin,
	output logic                   low_channel_output_pin,
	output logic                   high_channel_output_pin,
	output logic                   low_channel_match_irq,
	output logic                   high_channel_match_irq
);
	// ----------------------------------------------------------------------
	// Decode helper
	// ----------------------------------------------------------------------
	function automatic logic word_hit(input logic [ADDR_W-1:0] a, input logic [7:0] off);
		word_hit = (a == ADDR_W'(off));
	endfunction

	// ----------------------------------------------------------------------
	// Bus slave state
	// ----------------------------------------------------------------------
	logic              aw_full_r;
	logic              w_full_r;
	logic [ADDR_W-1:0] waddr_r;
	logic [7:0]        wbyte_r;
	logic              wlane_r;
	wire               aw_take = awvalid & awready;
	wire               w_take  = wvalid & wready;
	wire               ar_take = arvalid & arready;
	wire               do_wr   = aw_full_r & w_full_r;
	wire               aw_full_nxt = (aw_full_r & ~do_wr) | aw_take;
	wire               w_full_nxt  = (w_full_r & ~do_wr) | w_take;
	wire               bvalid_nxt  = do_wr | (bvalid & ~bready);
	wire               rvalid_nxt  = ar_take | (rvalid & ~rready);
	wire               wr_en       = do_wr & wlane_r;

	wire wr_mode0 = wr_en & word_hit(waddr_r, `OFF_MODE0);
	wire wr_mode1 = wr_en & word_hit(waddr_r, `OFF_MODE1);
	wire wr_sel0  = wr_en & word_hit(waddr_r, `OFF_SEL0);
	wire wr_sel1  = wr_en & word_hit(waddr_r, `OFF_SEL1);
	wire wr_cmp0  = wr_en & word_hit(waddr_r, `OFF_CMP0);
	wire wr_cmp1  = wr_en & word_hit(waddr_r, `OFF_CMP1);
	wire wr_known = word_hit(waddr_r, `OFF_MODE0) | word_hit(waddr_r, `OFF_MODE1)
		| word_hit(waddr_r, `OFF_SEL0) | word_hit(waddr_r, `OFF_SEL1)
		| word_hit(waddr_r, `OFF_CMP0) | word_hit(waddr_r, `OFF_CMP1)
		| word_hit(waddr_r, `OFF_CNT0) | word_hit(waddr_r, `OFF_CNT1);

	// ----------------------------------------------------------------------
	// Timer registers
	// ----------------------------------------------------------------------
	logic [1:0][7:0] mode_r;
	logic [1:0][2:0] sel_r;
	logic [1:0][7:0] cmp_r;
	logic [1:0][7:0] cmp_act_r;
	logic [1:0][7:0] cnt_r;
	logic [1:0]      pend_r;
	logic [1:0]      arm_r;
	logic [1:0]      ff_r;
	logic [1:0]      act_r;
	wire  [1:0]      tick;

	wire [1:0]       wr_mode = {wr_mode1, wr_mode0};
	wire [1:0]       wr_cmp  = {wr_cmp1, wr_cmp0};
	wire             casc    = mode_r[1][`BIT_CASC];
	wire [15:0]      cnt16   = {cnt_r[1], cnt_r[0]};
	wire [15:0]      cmp16   = {cmp_act_r[1], cmp_act_r[0]};
	wire             m16     = (cnt16 == cmp16);

	wire [1:0]       run_w;
	wire [1:0]       pwm_w;
	wire [1:0]       tog_w;
	wire [1:0]       oe_w;
	wire [1:0]       step;
	wire [1:0]       hit;
	wire [1:0]       ovf;
	wire [1:0]       pwm_end;
	wire [1:0][7:0]  cnt_plus;
	wire [1:0][7:0]  cmp_eff;
	wire [1:0][7:0]  cnt_nxt;
	wire [1:0][7:0]  cmp_act_nxt;
	wire [1:0][7:0]  mode_nxt;
	wire [1:0]       pend_nxt;
	wire [1:0]       arm_nxt;
	wire [1:0]       ff_nxt;
	wire [1:0]       act_nxt;
	wire [1:0]       out_nxt;
	wire [1:0]       irq_nxt;
	wire [1:0]       cnt_en;
	wire [7:0]       mode_mask [2];

	assign mode_mask[0] = `MODE0_MASK;
	assign mode_mask[1] = `MODE1_MASK;

	// In cascade the high counter follows the low channel's count clock.
	count_tick_gen u_tick0
	(
		.aclk      (aclk),
		.aresetn   (aresetn),
		.event_pin (low_channel_event_pin),
		.clk_sel   (timer_pkg::clk_sel_t'(sel_r[0])),
		.tick      (tick[0])
	);

	count_tick_gen u_tick1
	(
		.aclk      (aclk),
		.aresetn   (aresetn),
		.event_pin (high_channel_event_pin),
		.clk_sel   (timer_pkg::clk_sel_t'(sel_r[1])),
		.tick      (tick[1])
	);

	// ----------------------------------------------------------------------
	// Per-channel counting, compare and output logic
	// ----------------------------------------------------------------------
	for (genvar g = 0; g < 2; g++)
	begin : g_ch
		assign run_w[g] = mode_r[g][`BIT_RUN];
		assign pwm_w[g] = mode_r[g][`BIT_PWM] & ~casc;
		assign tog_w[g] = mode_r[g][`BIT_TOGPOL];
		assign oe_w[g]  = mode_r[g][`BIT_OE];
		if (g == 0)
		begin : g_lo
			assign step[g]   = run_w[0] & tick[0];
			assign cnt_en[g] = 1'b1;
			assign hit[g]    = ~pwm_w[g] & step[0] & (casc ? m16 : (cnt_r[0] == cmp_act_r[0]));
			assign irq_nxt[g] = hit[g] | pwm_end[g];
		end
		else
		begin : g_hi
			assign step[g]   = run_w[1] & (casc ? (run_w[0] & tick[0]) : tick[1]);
			assign cnt_en[g] = ~casc | (cnt_r[0] == `CNT_MAX);
			assign hit[g]    = ~pwm_w[g] & step[g]
				& (casc ? m16 : (cnt_r[1] == cmp_act_r[1]));
			assign irq_nxt[g] = (hit[g] | pwm_end[g]) & ~casc;
		end
		assign cnt_plus[g] = cnt_r[g] + 8'h01;
		assign ovf[g]      = pwm_w[g] & step[g] & (cnt_r[g] == `CNT_MAX);
		assign cmp_eff[g]  = (ovf[g] & arm_r[g]) ? cmp_r[g] : cmp_act_r[g];
		assign pwm_end[g]  = pwm_w[g] & step[g] & (cnt_plus[g] == cmp_eff[g]);
		assign cnt_nxt[g]  = !run_w[g] ? `RST_BYTE
			: hit[g] ? `RST_BYTE
			: (step[g] & cnt_en[g]) ? cnt_plus[g]
			: cnt_r[g];
		// The compare value is used directly unless a PWM period is running.
		assign cmp_act_nxt[g] = (pwm_w[g] & run_w[g]) ? cmp_eff[g] : cmp_r[g];
		assign pend_nxt[g] = wr_cmp[g] | (pend_r[g] & ~(step[g] & (cnt_r[g] == `CNT_PRE_MAX)));
		assign arm_nxt[g]  = (step[g] & (cnt_r[g] == `CNT_PRE_MAX)) ? pend_r[g]
			: (ovf[g] ? 1'b0 : arm_r[g]);
		assign mode_nxt[g] = wr_mode[g] ? (wbyte_r & mode_mask[g]) : mode_r[g];
		// Level set/clear works outside PWM only; a write beats a toggle.
		assign ff_nxt[g] = (wr_mode[g] & ~wbyte_r[`BIT_PWM] & wbyte_r[`BIT_FF_SET]) ? 1'b1
			: (wr_mode[g] & ~wbyte_r[`BIT_PWM] & wbyte_r[`BIT_FF_CLR]) ? 1'b0
			: (hit[g] & tog_w[g]) ? ~ff_r[g]
			: ff_r[g];
		assign act_nxt[g] = (!run_w[g] | !pwm_w[g]) ? 1'b0
			: pwm_end[g] ? 1'b0
			: ovf[g] ? 1'b1
			: act_r[g];
		assign out_nxt[g] = oe_w[g] & (mode_r[g][`BIT_PWM] ? (act_r[g] ^ tog_w[g]) : ff_r[g]);
	end

	// ----------------------------------------------------------------------
	// Read path
	// ----------------------------------------------------------------------
	wire [7:0] rd_byte =
		word_hit(araddr, `OFF_MODE0) ? mode_r[0]
		: word_hit(araddr, `OFF_MODE1) ? mode_r[1]
		: word_hit(araddr, `OFF_SEL0) ? {5'h00, sel_r[0]}
		: word_hit(araddr, `OFF_SEL1) ? {5'h00, sel_r[1]}
		: word_hit(araddr, `OFF_CMP0) ? cmp_r[0]
		: word_hit(araddr, `OFF_CMP1) ? cmp_r[1]
		: word_hit(araddr, `OFF_CNT0) ? cnt_r[0]
		: word_hit(araddr, `OFF_CNT1) ? cnt_r[1]
		: `RST_BYTE;
	wire rd_known = word_hit(araddr, `OFF_MODE0) | word_hit(araddr, `OFF_MODE1)
		| word_hit(araddr, `OFF_SEL0) | word_hit(araddr, `OFF_SEL1)
		| word_hit(araddr, `OFF_CMP0) | word_hit(araddr, `OFF_CMP1)
		| word_hit(araddr, `OFF_CNT0) | word_hit(araddr, `OFF_CNT1);

	// ----------------------------------------------------------------------
	// Flip-flops
	// ----------------------------------------------------------------------
	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			aw_full_r <= 1'b0;
			w_full_r  <= 1'b0;
			waddr_r   <= '0;
			wbyte_r   <= `RST_BYTE;
			wlane_r   <= 1'b0;
			awready   <= 1'b0;
			wready    <= 1'b0;
			bvalid    <= 1'b0;
			bresp     <= `RESP_OKAY;
			arready   <= 1'b0;
			rvalid    <= 1'b0;
			rdata     <= 32'h00000000;
			rresp     <= `RESP_OKAY;
		end
		else
		begin
			aw_full_r <= aw_full_nxt;
			w_full_r  <= w_full_nxt;
			awready   <= ~aw_full_nxt & ~bvalid_nxt;
			wready    <= ~w_full_nxt & ~bvalid_nxt;
			bvalid    <= bvalid_nxt;
			arready   <= ~rvalid_nxt;
			rvalid    <= rvalid_nxt;
			if (aw_take)
				waddr_r <= awaddr;
			if (w_take)
			begin
				wbyte_r <= wdata[7:0];
				wlane_r <= wstrb[0];
			end
			if (do_wr)
				bresp <= wr_known ? `RESP_OKAY : `RESP_SLVERR;
			if (ar_take)
			begin
				rdata <= {24'h000000, rd_byte};
				rresp <= rd_known ? `RESP_OKAY : `RESP_SLVERR;
			end
		end
	end

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			mode_r    <= '0;
			sel_r     <= '0;
			cmp_r     <= '0;
			cmp_act_r <= '0;
			cnt_r     <= '0;
			pend_r    <= 2'h0;
			arm_r     <= 2'h0;
			ff_r      <= 2'h0;
			act_r     <= 2'h0;
			low_channel_output_pin  <= 1'b0;
			high_channel_output_pin <= 1'b0;
			low_channel_match_irq   <= 1'b0;
			high_channel_match_irq  <= 1'b0;
		end
		else
		begin
			mode_r    <= mode_nxt;
			sel_r[0]  <= wr_sel0 ? wbyte_r[2:0] : sel_r[0];
			sel_r[1]  <= wr_sel1 ? wbyte_r[2:0] : sel_r[1];
			cmp_r[0]  <= wr_cmp0 ? wbyte_r : cmp_r[0];
			cmp_r[1]  <= wr_cmp1 ? wbyte_r : cmp_r[1];
			cmp_act_r <= cmp_act_nxt;
			cnt_r     <= cnt_nxt;
			pend_r    <= pend_nxt;
			arm_r     <= arm_nxt;
			ff_r      <= ff_nxt;
			act_r     <= act_nxt;
			low_channel_output_pin  <= out_nxt[0];
			high_channel_output_pin <= out_nxt[1];
			low_channel_match_irq   <= irq_nxt[0];
			high_channel_match_irq  <= irq_nxt[1];
		end
	end

	// ----------------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------------
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);

	sequence s_arm_seen;
		step[0] && pwm_w[0] && cnt_r[0] == `CNT_PRE_MAX && pend_r[0];
	endsequence

	sequence s_wrap_next;
		ovf[0] && arm_r[0];
	endsequence

	chk_oe_forces_low: assert property (!oe_w[0] |=> !low_channel_output_pin)
		else $error("disabled output not low");
	chk_match_clears: assert property
		(step[0] && !pwm_w[0] && !casc && cnt_r[0] == cmp_act_r[0] && run_w[0]
		|=> cnt_r[0] == `RST_BYTE && low_channel_match_irq)
		else $error("match did not clear and interrupt");
	chk_edge_counts: assert property
		(step[0] && !pwm_w[0] && !casc && cnt_r[0] != cmp_act_r[0] && run_w[0]
		|=> cnt_r[0] == $past(cnt_r[0]) + 8'h01)
		else $error("valid edge did not increment");
	chk_stop_clears: assert property (!run_w[1] |=> cnt_r[1] == `RST_BYTE)
		else $error("stopped counter not zero");
	chk_square_toggle: assert property
		(hit[0] && tog_w[0] && !wr_mode[0] |=> ff_r[0] != $past(ff_r[0]))
		else $error("match did not invert flop");
	// Two quiet cycles are needed: the pin follows the run bit two cycles late, through act_r.
	chk_pwm_stop: assert property
		((mode_r[0][`BIT_PWM] && !run_w[0] && oe_w[0] && !wr_mode[0]) ##1 (!wr_mode[0])
		|=> low_channel_output_pin == tog_w[0])
		else $error("stopped PWM not inactive");
	chk_pwm_overflow: assert property
		(ovf[0] && cmp_eff[0] != `RST_BYTE |=> act_r[0])
		else $error("overflow did not start active phase");
	chk_pwm_irq: assert property (pwm_end[0] |=> low_channel_match_irq && !act_r[0])
		else $error("PWM match gave no interrupt");
	chk_reload_arm: assert property (s_arm_seen |=> arm_r[0])
		else $error("pending compare not armed");
	chk_reload_seq: assert property
		(s_wrap_next |=> cmp_act_r[0] == $past(cmp_r[0]))
		else $error("compare not transferred at overflow");
	chk_casc_match: assert property
		(casc && run_w[0] && run_w[1] && tick[0] && m16
		|=> cnt16 == 16'h0000 && low_channel_match_irq && !high_channel_match_irq)
		else $error("cascade match did not clear");
endmodule // dual_event_timer

// ### logic/timer_consts.svh
/*
 * Register offsets, field positions, reset values and bus response codes for
 * the dual 8-bit timer/event counter. Included by the design modules and the
 * bench; holds definitions only.
 */
`ifndef TIMER_CONSTS_SVH
`define TIMER_CONSTS_SVH

// ----------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------
`define OFF_MODE0      8'h00
`define OFF_MODE1      8'h04
`define OFF_SEL0       8'h08
`define OFF_SEL1       8'h0C
`define OFF_CMP0       8'h10
`define OFF_CMP1       8'h14
`define OFF_CNT0       8'h18
`define OFF_CNT1       8'h1C

// ----------------------------------------------------------------------
// Mode control fields
// ----------------------------------------------------------------------
`define BIT_RUN        7
`define BIT_PWM        6
`define BIT_CASC       4
`define BIT_FF_SET     3
`define BIT_FF_CLR     2
`define BIT_TOGPOL     1
`define BIT_OE         0
`define MODE0_MASK     8'hC3
`define MODE1_MASK     8'hD3

// ----------------------------------------------------------------------
// Reset values, limits and response codes
// ----------------------------------------------------------------------
`define RST_BYTE       8'h00
`define CNT_MAX        8'hFF
`define CNT_PRE_MAX    8'hFE
`define RESP_OKAY      2'h0
`define RESP_SLVERR    2'h2

`endif

// ### logic/timer_pkg.sv
/*
 * Types shared by the timer modules.
 * Assumes timer_consts.svh is on the include path.
 */
package timer_pkg;
	typedef enum logic [2:0]
	{
		SEL_EDGE_FALL = 3'h0,
		SEL_EDGE_RISE = 3'h1,
		SEL_DIV1      = 3'h2,
		SEL_DIV2      = 3'h3,
		SEL_DIV4      = 3'h4,
		SEL_DIV64     = 3'h5,
		SEL_DIV256    = 3'h6,
		SEL_CHAIN     = 3'h7
	} clk_sel_t;
endpackage

// ### logic/count_tick_gen.sv
/*
 * Count-clock source for one channel: a synchronised event pin edge or a
 * divided system clock, delivered as a one-cycle tick.
 * Assumes event_pin is asynchronous to aclk.
 */
`timescale 1ns/100ps
`include "timer_consts.svh"
module count_tick_gen
(
	input  wire logic                    aclk,
	input  wire logic                    aresetn,
	input  wire logic                    event_pin,
	input  wire timer_pkg::clk_sel_t     clk_sel,
	output logic                         tick
);
	logic [2:0] sync_r;
	logic       filt_r;
	logic [7:0] pre_r;
	logic       filt_nxt;
	logic       tick_nxt;

	// ----------------------------------------------------------------------
	// Divider decode
	// ----------------------------------------------------------------------
	function automatic logic div_hit(input timer_pkg::clk_sel_t s, input logic [7:0] p);
		unique case (s)
			timer_pkg::SEL_DIV1:   div_hit = 1'b1;
			timer_pkg::SEL_DIV2:   div_hit = p[0];
			timer_pkg::SEL_DIV4:   div_hit = &p[1:0];
			timer_pkg::SEL_DIV64:  div_hit = &p[5:0];
			timer_pkg::SEL_DIV256: div_hit = &p;
			default:               div_hit = 1'b0;
		endcase
	endfunction

	// A level change is accepted only once the two late stages agree.
	assign filt_nxt = (sync_r[1] == sync_r[2]) ? sync_r[2] : filt_r;
	assign tick_nxt = ((clk_sel == timer_pkg::SEL_EDGE_FALL) & filt_r & ~filt_nxt)
		| ((clk_sel == timer_pkg::SEL_EDGE_RISE) & ~filt_r & filt_nxt)
		| div_hit(clk_sel, pre_r);

	always_ff @(posedge aclk)
	begin
		if (!aresetn)
		begin
			sync_r <= 3'h0;
			filt_r <= 1'b0;
			pre_r  <= `RST_BYTE;
			tick   <= 1'b0;
		end
		else
		begin
			sync_r <= {sync_r[1:0], event_pin};
			filt_r <= filt_nxt;
			pre_r  <= pre_r + 8'h01;
			tick   <= tick_nxt;
		end
	end

	chk_fall_edge_tick: assert property (@(posedge aclk) disable iff (!aresetn)
		(clk_sel == timer_pkg::SEL_EDGE_FALL && filt_r && !filt_nxt) |=> tick)
		else $error("falling edge gave no tick");
endmodule // count_tick_gen

// ### tb/tb.sv
/*
 * Self-checking bench for dual_event_timer: register access, event counting,
 * square wave, PWM and 16-bit cascade, driven over AXI4-Lite.
 * Assumes the design files are compiled first and timer_consts.svh is on the
 * include path.
 */
`timescale 1ns/100ps
`include "timer_consts.svh"
module tb;
	localparam int LIMIT = 20000;
	logic        aclk = 1'b0;
	logic        aresetn;
	logic        awvalid, awready, wvalid, wready, bvalid, bready;
	logic        arvalid, arready, rvalid, rready;
	logic [7:0]  awaddr, araddr;
	logic [31:0] wdata, rdata, rd_data;
	logic [3:0]  wstrb;
	logic [1:0]  bresp, rresp, resp;
	logic [1:0]  ev, out, irq;
	int          cyc, fails, tests_run, gap0, at0;
	int          irq_n [2];
	int          hi_n [2];
	// Rows: address, write data, expected read data, expected response.
	localparam logic [25:0] ROWS [7] = '{
		{`OFF_MODE0, 8'hFF, 8'hC3, 2'h0}, {`OFF_MODE0, 8'h00, 8'h00, 2'h0},
		{`OFF_MODE1, 8'h1C, 8'h10, 2'h0}, {`OFF_SEL0, 8'hFF, 8'h07, 2'h0},
		{`OFF_CMP1, 8'hA5, 8'hA5, 2'h0}, {`OFF_CNT1, 8'h55, 8'h00, 2'h0},
		{8'h20, 8'h12, 8'h00, 2'h2}};

	dual_event_timer dut_u (.aclk(aclk), .aresetn(aresetn), .awvalid(awvalid),
		.awready(awready), .awaddr(awaddr), .wvalid(wvalid), .wready(wready),
		.wdata(wdata), .wstrb(wstrb), .bvalid(bvalid), .bready(bready),
		.bresp(bresp), .arvalid(arvalid), .arready(arready), .araddr(araddr),
		.rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp),
		.low_channel_event_pin(ev[0]), .high_channel_event_pin(ev[1]),
		.low_channel_output_pin(out[0]), .high_channel_output_pin(out[1]),
		.low_channel_match_irq(irq[0]), .high_channel_match_irq(irq[1]));

	always #5 aclk = ~aclk;

	// ------------------------------------------------------------------
	// Monitors
	// ------------------------------------------------------------------
	// Sampling on the falling edge keeps the counts clear of bus updates.
	always @(negedge aclk)
	begin
		cyc++;
		for (int i = 0; i < 2; i++)
		begin
			if (irq[i] === 1'b1) irq_n[i]++;
			if (out[i] === 1'b1) hi_n[i]++;
		end
		if (irq[0] === 1'b1)
		begin
			gap0 = cyc - at0;
			at0 = cyc;
		end
		if (cyc >= LIMIT)
		begin
			fails++;
			test_done();
		end
	end

	// ------------------------------------------------------------------
	// Tasks
	// ------------------------------------------------------------------
	task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		tests_run++;
		if (seen !== exp)
		begin
			fails++;
			$display("wrong value %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		logic aw_ok;
		logic w_ok;
		aw_ok = 1'b0;
		w_ok = 1'b0;
		@(posedge aclk);
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		awaddr <= a;
		wdata <= {24'h0, d};
		bready <= 1'b1;
		do
		begin
			@(posedge aclk);
			if (!aw_ok && awready === 1'b1)
			begin
				aw_ok = 1'b1;
				awvalid <= 1'b0;
			end
			if (!w_ok && wready === 1'b1)
			begin
				w_ok = 1'b1;
				wvalid <= 1'b0;
			end
		end while (!(aw_ok && w_ok));
		do @(posedge aclk); while (bvalid !== 1'b1);
		resp = bresp;
		bready <= 1'b0;
	endtask

	task automatic rd(input logic [7:0] a);
		@(posedge aclk);
		arvalid <= 1'b1;
		araddr <= a;
		rready <= 1'b1;
		do @(posedge aclk); while (arready !== 1'b1);
		arvalid <= 1'b0;
		do @(posedge aclk); while (rvalid !== 1'b1);
		rd_data = rdata;
		resp = rresp;
		rready <= 1'b0;
	endtask

	task automatic cycles(input int n);
		repeat (n) @(posedge aclk);
	endtask

	// An event pin holds each level six cycles, above the synchroniser minimum.
	task automatic pulse(input int ch);
		@(posedge aclk);
		ev[ch] <= ~ev[ch];
		cycles(6);
		ev[ch] <= ~ev[ch];
		cycles(6);
	endtask

	task automatic test_done;
		$display("comparisons %0d mismatches %0d", tests_run, fails);
		if (fails == 0 && tests_run > 0)
			$display("Regression OK");
		else
			$display("Regression broken");
		$finish;
	endtask

	// ------------------------------------------------------------------
	// Main sequence
	// ------------------------------------------------------------------
	initial
	begin
		aresetn = 1'b0;
		{awvalid, wvalid, bready, arvalid, rready} = 5'h00;
		awaddr = 8'h00;
		araddr = 8'h00;
		wdata = 32'h0;
		wstrb = 4'h1;
		ev = 2'h0;
		cycles(16);
		aresetn <= 1'b1;
		cycles(2);
		for (int i = 0; i < 8; i++)
		begin
			rd(8'(i * 4));
			chk("reset value", rd_data, 32'h0);
		end
		foreach (ROWS[i])
		begin
			wr(ROWS[i][25:18], ROWS[i][17:10]);
			chk("write resp", 32'(resp), 32'(ROWS[i][1:0]));
			rd(ROWS[i][25:18]);
			chk("readback", rd_data, 32'(ROWS[i][9:2]));
			chk("read resp", 32'(resp), 32'(ROWS[i][1:0]));
		end
		// The table left the cascade bit set; single channels need it clear.
		wr(`OFF_MODE1, 8'h00);
		// Event counting on both channels and both edge choices.
		for (int ch = 0; ch < 2; ch++)
			for (int s = 0; s < 2; s++)
			begin
				@(posedge aclk);
				ev[ch] <= (s == 0);
				wr(8'(`OFF_MODE0 + ch * 4), 8'h00);
				wr(8'(`OFF_SEL0 + ch * 4), 8'(s));
				wr(8'(`OFF_CMP0 + ch * 4), 8'h02);
				wr(8'(`OFF_MODE0 + ch * 4), 8'h80);
				irq_n[ch] = 0;
				pulse(ch);
				pulse(ch);
				rd(8'(`OFF_CNT0 + ch * 4));
				chk("event count", rd_data, 32'h2);
				chk("early match", 32'(irq_n[ch]), 32'h0);
				pulse(ch);
				cycles(10);
				chk("match after N+1", 32'(irq_n[ch]), 32'h1);
				rd(8'(`OFF_CNT0 + ch * 4));
				chk("cleared on match", rd_data, 32'h0);
			end
		// Square wave with N = 3: period eight clocks.
		wr(`OFF_MODE0, 8'h00);
		wr(`OFF_SEL0, 8'h02);
		wr(`OFF_CMP0, 8'h03);
		wr(`OFF_MODE0, 8'h0B);
		wr(`OFF_MODE0, 8'h83);
		cycles(20);
		irq_n[0] = 0;
		hi_n[0] = 0;
		cycles(80);
		chk("square high time", 32'(hi_n[0]), 32'd40);
		chk("square matches", 32'(irq_n[0]), 32'd20);
		chk("square match gap", 32'(gap0), 32'd4);
		wr(`OFF_MODE0, 8'h82);
		cycles(3);
		chk("output disabled", 32'(out[0]), 32'h0);
		// High channel square wave on the halved clock, N = 1: period eight clocks.
		wr(`OFF_MODE1, 8'h00);
		wr(`OFF_SEL1, 8'h03);
		wr(`OFF_CMP1, 8'h01);
		wr(`OFF_MODE1, 8'h07);
		wr(`OFF_MODE1, 8'h83);
		cycles(20);
		hi_n[1] = 0;
		cycles(40);
		chk("square high time ch1", 32'(hi_n[1]), 32'd20);
		wr(`OFF_MODE1, 8'h00);
		// PWM, N = 40H, high active then low active.
		wr(`OFF_MODE0, 8'h00);
		wr(`OFF_CMP0, 8'h40);
		wr(`OFF_MODE0, 8'h41);
		hi_n[0] = 0;
		wr(`OFF_MODE0, 8'hC1);
		cycles(200);
		chk("pwm before overflow", 32'(hi_n[0]), 32'h0);
		cycles(100);
		hi_n[0] = 0;
		irq_n[0] = 0;
		cycles(512);
		chk("pwm active time", 32'(hi_n[0]), 32'd128);
		chk("pwm matches", 32'(irq_n[0]), 32'd2);
		wr(`OFF_MODE0, 8'hC3);
		cycles(10);
		hi_n[0] = 0;
		cycles(256);
		chk("pwm low active", 32'(hi_n[0]), 32'd192);
		wr(`OFF_CMP0, 8'h80);
		rd(`OFF_CMP0);
		chk("compare read", rd_data, 32'h80);
		cycles(600);
		hi_n[0] = 0;
		cycles(256);
		chk("pwm reload", 32'(hi_n[0]), 32'd128);
		wr(`OFF_MODE0, 8'h43);
		cycles(3);
		chk("pwm stopped level", 32'(out[0]), 32'h1);
		rd(`OFF_CNT0);
		chk("stopped counter", rd_data, 32'h0);
		// Cascade, N = 0105H: interval 262 clocks.
		wr(`OFF_MODE0, 8'h00);
		wr(`OFF_SEL1, 8'h07);
		wr(`OFF_CMP0, 8'h05);
		wr(`OFF_CMP1, 8'h01);
		wr(`OFF_MODE1, 8'h10);
		wr(`OFF_MODE1, 8'h90);
		wr(`OFF_MODE0, 8'h80);
		irq_n[1] = 0;
		cycles(1000);
		chk("cascade interval", 32'(gap0), 32'd262);
		chk("cascade high irq", 32'(irq_n[1]), 32'h0);
		// Reset in mid-run clears the registers.
		@(posedge aclk);
		aresetn <= 1'b0;
		cycles(2);
		aresetn <= 1'b1;
		cycles(2);
		rd(`OFF_CMP1);
		chk("compare after reset", rd_data, 32'h0);
		rd(`OFF_MODE1);
		chk("mode after reset", rd_data, 32'h0);
		test_done();
	end
endmodule // tb
